// [rtl/albps_pkg.sv]
// package: constants and carriers of the asynchronous local bus slave
package albps_pkg;

    // ========================================
    // bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    // ========================================
    // timing, ns and cycles at 100 MHz
    localparam int CLK_PERIOD_NS      = 10;
    localparam int WRITE8_MAX_NS      = 180;
    localparam int WRITE16_MAX_NS     = 260;
    localparam int COLL_MAX_NS        = 20;
    localparam int READ_DELAY_NS      = 20;
    localparam int READ8_INT_MAX_NS   = 220;
    localparam int READ16_INT_MAX_NS  = 300;
    // longest times round down
    localparam int WRITE8_CYC  = WRITE8_MAX_NS / CLK_PERIOD_NS;
    localparam int WRITE16_CYC = WRITE16_MAX_NS / CLK_PERIOD_NS;
    localparam int COLL_CYC    = COLL_MAX_NS / CLK_PERIOD_NS;
    localparam int RDLY_CYC    = READ_DELAY_NS / CLK_PERIOD_NS;
    localparam int READ8_CYC   = READ8_INT_MAX_NS / CLK_PERIOD_NS;
    localparam int READ16_CYC  = READ16_INT_MAX_NS / CLK_PERIOD_NS;
    localparam int CNT_W       = 6;

    // ========================================
    // carriers
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [1:0]        lanes;
    } albps_wr_s;

    typedef struct packed {
        logic        csN;
        logic        rdN;
        logic        wrN;
    } albps_strobe_s;

endpackage

// [rtl/albps_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module albps_sync
#(
    parameter logic RST_VAL = 1'b1
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // pin in, filtered level out
    input  wire logic pin,
    output logic      level
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    // change counts once stages two and three agree
    always_comb
    begin
        next_level = (s2 == s3) ? s3 : level;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1    <= RST_VAL;
            s2    <= RST_VAL;
            s3    <= RST_VAL;
            level <= RST_VAL;
        end
        else
        begin
            s1    <= pin;
            s2    <= s1;
            s3    <= s2;
            level <= next_level;
        end
    end
endmodule

// [rtl/albps_slave.sv]
// asynchronous 8/16-bit local bus slave with busy handshake
// Notes on behaviour
// - default: write starts at strobe rising edge
// - option: write starts at strobe falling edge
// - busy driven only under chip select
// - busy held until internal write finishes
// - pending write finishes before read runs
// - busy continuous across write then read
// - delayed read busy adds 20 ns
// - write takes 180 or 260 ns
// - same-address read after 8-bit write adds collision, rising-edge write mode only
// - other cases add no collision delay
// - data driven under read, released otherwise
// - read data valid when busy drops
`timescale 1ns/1ps
module albps_slave
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        nrst,
    // configuration
    input  wire logic                        busWide,
    input  wire logic                        writeOnFall,
    input  wire logic                        delayedReadBusy,
    // host bus pins
    input  wire logic                        chipSelectN,
    input  wire logic                        readStrobeN,
    input  wire logic                        write_strobe_low,
    input  wire logic                        byte_high_enable,
    input  wire logic [albps_pkg::ADDR_W-1:0] addrIn,
    input  wire logic [albps_pkg::DATA_W-1:0] dataIn,
    output logic      [albps_pkg::DATA_W-1:0] dataOut,
    output logic                             dataOeN,
    output logic                             busy,
    output logic                             busyOeN,
    // internal memory port
    output logic                             memWrite,
    output logic                             memRead,
    output logic      [albps_pkg::ADDR_W-1:0] memAddr,
    output logic      [albps_pkg::DATA_W-1:0] memWdata,
    output logic      [1:0]                  memLanes,
    input  wire logic [albps_pkg::DATA_W-1:0] memRdata
);
    import albps_pkg::*;

    // ========================================
    // synchronised strobes
    albps_strobe_s st;
    albps_sync u_cs (.clk(clk), .nrst(nrst), .pin(chipSelectN), .level(st.csN));
    albps_sync u_rd (.clk(clk), .nrst(nrst), .pin(readStrobeN), .level(st.rdN));
    albps_sync u_wr (.clk(clk), .nrst(nrst), .pin(write_strobe_low), .level(st.wrN));

    logic prevWrN;
    logic wrFall;
    logic wrRise;
    logic csOn;
    logic rdOn;
    assign wrFall = prevWrN & ~st.wrN & ~st.csN;
    assign wrRise = ~prevWrN & st.wrN & ~st.csN;
    assign csOn   = ~st.csN;
    assign rdOn   = ~st.csN & ~st.rdN;

    // ========================================
    // lane decode
    function automatic logic [1:0] lanesOf(input logic wide, input logic hiEnN,
                                          input logic a0);
        logic [1:0] l;
        l = 2'h0;
        if (!wide)
            l = a0 ? 2'h2 : 2'h1;
        else
            l = {~hiEnN, ~a0};
        return l;
    endfunction

    // ========================================
    // state machine
    typedef enum logic [3:0]
    {
        ST_IDLE  = 4'h1,
        ST_WRITE = 4'h2,
        ST_READ  = 4'h4,
        ST_DONE  = 4'h8
    } albps_state_e;

    albps_state_e state;
    albps_state_e next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    albps_wr_s        lastWr;
    albps_wr_s        next_lastWr;
    logic             lastWrValid;
    logic             next_lastWrValid;
    logic             pendingWr;
    logic             next_pendingWr;
    logic [DATA_W-1:0] next_dataOut;
    logic             next_memWrite;
    logic             next_memRead;
    logic             wrTrig;
    logic [1:0]       rdLanes;
    logic             coll;
    logic [CNT_W-1:0] readCyc;

    always_comb
    begin
        // write trigger edge select
        // rising edge by default
        wrTrig  = writeOnFall ? wrFall : wrRise;
        rdLanes = lanesOf(busWide, byte_high_enable, addrIn[0]);
        // same address, an 8-bit write involved
        coll = lastWrValid && !writeOnFall &&
               (lastWr.addr[ADDR_W-1:1] == addrIn[ADDR_W-1:1]) &&
               (lastWr.lanes != 2'h3) && ((lastWr.lanes & rdLanes) != 2'h0);
        readCyc = CNT_W'(((rdLanes == 2'h3) ? READ16_CYC : READ8_CYC) +
                  (coll ? COLL_CYC : 0) + (delayedReadBusy ? RDLY_CYC : 0));
        next_state       = state;
        next_cnt         = cnt;
        next_lastWr      = lastWr;
        next_lastWrValid = lastWrValid;
        next_pendingWr   = pendingWr;
        next_dataOut     = dataOut;
        next_memWrite    = 1'b0;
        next_memRead     = 1'b0;
        // capture on the selected strobe edge
        if (wrTrig)
        begin
            next_lastWr.addr  = addrIn;
            next_lastWr.data  = dataIn;
            next_lastWr.lanes = lanesOf(busWide, byte_high_enable, addrIn[0]);
            next_pendingWr    = 1'b1;
        end
        case (state)
            ST_IDLE:
            begin
                if (pendingWr)
                begin
                    next_state     = ST_WRITE;
                    next_memWrite  = 1'b1;
                    next_pendingWr = wrTrig;
                    next_cnt = CNT_W'((lastWr.lanes == 2'h3) ? WRITE16_CYC : WRITE8_CYC);
                end
                else if (rdOn)
                begin
                    next_state = ST_READ;
                    // idle cycle already shows busy
                    next_cnt   = readCyc - CNT_W'(1);
                end
            end
            ST_WRITE:
            begin
                // write runs on even after chip select drops
                if (cnt <= CNT_W'(1))
                begin
                    next_state       = ST_IDLE;
                    next_lastWrValid = 1'b1;
                    next_cnt         = '0;
                end
                else
                    next_cnt = cnt - CNT_W'(1);
            end
            ST_READ:
            begin
                if (!rdOn)
                    next_state = ST_IDLE;
                else if (cnt <= CNT_W'(1))
                begin
                    next_memRead     = 1'b1;
                    next_dataOut     = memRdata;
                    next_lastWrValid = 1'b0;
                    next_state       = ST_DONE;
                end
                else
                    next_cnt = cnt - CNT_W'(1);
            end
            ST_DONE:
            begin
                if (!rdOn)
                    next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state       <= ST_IDLE;
            cnt         <= '0;
            lastWr      <= '0;
            lastWrValid <= 1'b0;
            pendingWr   <= 1'b0;
            dataOut     <= '0;
            memWrite    <= 1'b0;
            memRead     <= 1'b0;
            prevWrN     <= 1'b1;
        end
        else
        begin
            state       <= next_state;
            cnt         <= next_cnt;
            lastWr      <= next_lastWr;
            lastWrValid <= next_lastWrValid;
            pendingWr   <= next_pendingWr;
            dataOut     <= next_dataOut;
            memWrite    <= next_memWrite;
            memRead     <= next_memRead;
            prevWrN     <= st.wrN;
        end
    end

    // ========================================
    // memory port and pins
    // read address must stand while the word is fetched
    assign memAddr  = (state == ST_READ || memRead) ? addrIn : lastWr.addr;
    assign memWdata = lastWr.data;
    assign memLanes = lastWr.lanes;

    assign busyOeN = ~csOn;
    assign busy = csOn && (pendingWr || state == ST_WRITE ||
                  (rdOn && state != ST_DONE));
    // drive data while read strobe and chip select low
    assign dataOeN = ~rdOn;
endmodule

// [tb/albps_slave_sva.sv]
// checker: timing relations at the slave ports
`timescale 1ns/1ps
module albps_slave_sva
(
    // clock, reset, modes
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        busWide,
    input wire logic        writeOnFall,
    // host pins
    input wire logic        chipSelectN,
    input wire logic        readStrobeN,
    input wire logic        write_strobe_low,
    input wire logic        dataOeN,
    input wire logic        busy,
    input wire logic        busyOeN,
    // memory side
    input wire logic        memWrite,
    input wire logic        memRead,
    input wire logic [15:0] memAddr,
    input wire logic [1:0]  memLanes
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // ====================
    // assertions
    a_rise_starts_write: assert property ($rose(write_strobe_low) && !writeOnFall
        |-> ##[2:6] memWrite) else $error("write not started at strobe rise");
    a_fall_starts_write: assert property ($fell(write_strobe_low) && writeOnFall
        |-> ##[2:6] memWrite) else $error("write not started at strobe fall");
    a_cs_frees_busy: assert property ($rose(chipSelectN)
        |-> ##[1:6] busyOeN) else $error("busy still driven");
    a_write_holds_busy: assert property (memWrite && !busyOeN
        |=> (busy || busyOeN)[*8]) else $error("busy dropped in write");
    a_read_waits_write: assert property (memWrite
        |=> !memRead[*8]) else $error("read overtook write");
    a_busy_until_read: assert property (memRead && !busyOeN
        |-> $past(busy) && $past(busy, 20)) else $error("busy gone before data");
    a_rd_drives_data: assert property ($fell(readStrobeN) && !chipSelectN
        |-> ##[2:6] !dataOeN) else $error("data not driven");
    a_rd_frees_data: assert property ($rose(readStrobeN) || $rose(chipSelectN)
        |-> ##[1:6] dataOeN) else $error("data not released");
    a_byte_lane_pick: assert property (memWrite && !busWide
        |-> memLanes == {memAddr[0], !memAddr[0]}) else $error("wrong byte lane");
    cover property (memWrite && busWide);
    cover property (memWrite && writeOnFall);
    cover property (memRead && !busyOeN);
endmodule

bind albps_slave albps_slave_sva u_sva
(
    .clk(clk), .nrst(nrst), .busWide(busWide), .writeOnFall(writeOnFall),
    .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
    .write_strobe_low(write_strobe_low), .dataOeN(dataOeN), .busy(busy),
    .busyOeN(busyOeN), .memWrite(memWrite), .memRead(memRead),
    .memAddr(memAddr), .memLanes(memLanes)
);

// [tb/albps_host.sv]
// host model: microcontroller driving the bus pins
`timescale 1ns/1ps
module albps_host
(
    // clock and device answer
    input  wire logic        clk,
    input  wire logic        busy,
    input  wire logic [15:0] rdata,
    // pins toward the device
    output logic             csN,
    output logic             rdN,
    output logic             write_strobe_low,
    output logic             byte_high_enable,
    output logic [15:0]      addr,
    output logic [15:0]      data
);
    logic hung = 1'b0;
    initial
    begin
        csN = 1;
        rdN = 1;
        write_strobe_low = 1;
        byte_high_enable = 1;
        addr = 16'h0;
        data = 16'h0;
    end
    // ====================
    // bus cycles
    task automatic wr(input logic [15:0] a, d, input logic hb, hold);
        @(negedge clk);
        csN = 0;
        addr = a;
        data = d;
        byte_high_enable = hb;
        write_strobe_low = 0;
        repeat (3) @(negedge clk);
        write_strobe_low = 1;
        // capture sits behind the synchroniser, so data stays a while
        repeat (6) @(negedge clk);
        if (hold)
        begin
            for (int i = 0; busy && i < 40; i++) @(negedge clk);
            hung |= busy;
            csN = 1;
            // deselect must outlast the input filter
            repeat (4) @(negedge clk);
        end
        // released lines show the inverse
        data = ~d;
    endtask
    task automatic idle();
        @(negedge clk);
        csN = 1;
    endtask
    task automatic rd(input logic [15:0] a, input logic hb, output logic [15:0] d,
                      output int n);
        bit seen;
        seen = 0;
        n = 0;
        @(negedge clk);
        csN = 0;
        rdN = 0;
        addr = a;
        byte_high_enable = hb;
        // strobes and address held until busy drops
        for (int i = 0; i < 120; i++)
        begin
            @(negedge clk);
            if (busy) begin seen = 1; n++; end else if (seen) break;
        end
        hung |= busy || !seen;
        // data taken only after busy low
        d = rdata;
        rdN = 1;
        csN = 1;
        // release must outlast the input filter
        repeat (4) @(negedge clk);
    endtask
endmodule

// [tb/async_local_bus_pdi_slave_tb_top.sv]
// testbench: slave scenarios against a small word memory
`timescale 1ns/1ps
module async_local_bus_pdi_slave_tb_top;
    import albps_pkg::*;
    logic        clk, nrst, busWide, writeOnFall, delayedReadBusy;
    logic        csN, rdN, wrN, hiLaneN, busy, busyOeN, dataOeN, memWrite, memRead;
    logic [15:0] addr, wdata, dataOut, memAddr, memWdata, memRdata, d;
    logic [1:0]  lanes;
    logic [15:0] mem [16];
    int          failures, tests_run, n;
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // combinational memory, byte lanes written apart
    assign memRdata = mem[memAddr[4:1]];
    always @(posedge clk)
    begin
        if (memWrite && lanes[0]) mem[memAddr[4:1]][7:0] <= memWdata[7:0];
        if (memWrite && lanes[1]) mem[memAddr[4:1]][15:8] <= memWdata[15:8];
    end
    albps_slave u_dut (.clk(clk), .nrst(nrst), .busWide(busWide),
        .writeOnFall(writeOnFall), .delayedReadBusy(delayedReadBusy),
        .chipSelectN(csN), .readStrobeN(rdN), .write_strobe_low(wrN),
        .byte_high_enable(hiLaneN), .addrIn(addr), .dataIn(wdata), .dataOut(dataOut),
        .dataOeN(dataOeN), .busy(busy), .busyOeN(busyOeN), .memWrite(memWrite),
        .memRead(memRead), .memAddr(memAddr), .memWdata(memWdata),
        .memLanes(lanes), .memRdata(memRdata));
    albps_host u_host (.clk(clk), .busy(busy), .rdata(dataOut), .csN(csN), .rdN(rdN),
        .write_strobe_low(wrN), .byte_high_enable(hiLaneN), .addr(addr), .data(wdata));
    // ====================
    // checking and closing
    task automatic conclude();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        tests_run++;
        if (seen !== exp || u_host.hung)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
        if (u_host.hung)
            conclude();
    endtask
    task automatic t_coll8();
        u_host.wr(16'h0010, 16'h00a5, 1'b1, 1'b1);
        u_host.rd(16'h0010, 1'b1, d, n);
        chk("coll len", 16'(n), 16'(READ8_CYC + COLL_CYC));
        chk("coll data", d, 16'h00a5);
        u_host.wr(16'h0011, 16'h005a, 1'b1, 1'b1);
        u_host.rd(16'h0014, 1'b1, d, n);
        chk("plain len", 16'(n), 16'(READ8_CYC));
        chk("plain data", d, 16'h0000);
        delayedReadBusy = 1;
        u_host.rd(16'h0014, 1'b1, d, n);
        chk("slow len", 16'(n), 16'(READ8_CYC + RDLY_CYC));
        delayedReadBusy = 0;
    endtask
    task automatic t_wide();
        busWide = 1;
        u_host.wr(16'h0020, 16'ha5c3, 1'b0, 1'b1);
        u_host.rd(16'h0020, 1'b0, d, n);
        chk("wide len", 16'(n), 16'(READ16_CYC));
        chk("wide data", d, 16'ha5c3);
        u_host.wr(16'h0024, 16'h3c5a, 1'b0, 1'b0);
        u_host.rd(16'h0024, 1'b0, d, n);
        chk("chain data", d, 16'h3c5a);
        chk("chain long", 16'(n > READ16_CYC), 16'h1);
    endtask
    task automatic t_lane_cs();
        u_host.wr(16'h0028, 16'hffff, 1'b0, 1'b1);
        u_host.wr(16'h0028, 16'h0000, 1'b1, 1'b0);
        u_host.idle();
        repeat (6) @(negedge clk);
        chk("busy freed", busyOeN, 16'h1);
        repeat (30) @(negedge clk);
        u_host.rd(16'h0028, 1'b0, d, n);
        chk("lane data", d, 16'hff00);
        writeOnFall = 1;
        u_host.wr(16'h002c, 16'h1234, 1'b0, 1'b1);
        u_host.rd(16'h002c, 1'b0, d, n);
        chk("fall data", d, 16'h1234);
    endtask
    initial
    begin
        nrst = 0;
        busWide = 0;
        writeOnFall = 0;
        delayedReadBusy = 0;
        failures = 0;
        tests_run = 0;
        for (int i = 0; i < 16; i++) mem[i] = 16'h0;
        repeat (16) @(negedge clk);
        nrst = 1;
        repeat (6) @(negedge clk);
        chk("idle busy oe", busyOeN, 16'h1);
        chk("idle data oe", dataOeN, 16'h1);
        t_coll8();
        t_wide();
        t_lane_cs();
        conclude();
    end
endmodule
